//--- pkg/sfp_mgmt_cfg.svh
`ifndef SFP_MGMT_CFG_SVH
`define SFP_MGMT_CFG_SVH

// ============================================================
// Serial bus device addresses (7-bit part, R/W bit dropped)
`define DEV_ID_ADDR 7'h50
`define DEV_DIAG_ADDR 7'h51

// ============================================================
// Diagnostic page layout
`define DIAG_THRESH_END 8'h28
`define DIAG_LIVE_BASE 8'h60
`define DIAG_LIVE_STAT 8'h6E
`define DIAG_ALM_HI 8'h70
`define DIAG_ALM_LO 8'h71
`define DIAG_WRN_HI 8'h74
`define DIAG_WRN_LO 8'h75
`define DIAG_USER_BASE 8'h80

// ============================================================
// Local register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h01
`define REG_MASK 8'h02
`define REG_CAL_OFFSET 8'h03
`define REG_ID_INDEX 8'h04
`define REG_ID_DATA 8'h05
`define REG_LINE 8'h06

// ============================================================
// Field positions and reset values
`define CTRL_EXT_CAL_BIT 0
`define STS_WRITE_BIT 0
`define STS_FAULT_BIT 1
`define STS_LOS_BIT 2
`define STS_ALARM_BIT 3
`define CTRL_RST 8'h00
`define MASK_RST 4'h0
`define CAL_OFFSET_RST 8'h00
// Pin sync order {scl, sda, fault, los, txoff}
`define PIN_SYNC_RST 5'h19
`define BYTE_BITS 4'h8

`endif

//--- pkg/sfp_mgmt_pkg.sv
package sfp_mgmt_pkg;

    // ============================================================
    // Serial engine states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_DEV = 7'h02,
        S_DACK = 7'h04,
        S_RX = 7'h08,
        S_WACK = 7'h10,
        S_TX = 7'h20,
        S_HACK = 7'h40
    } serial_state_t;

    typedef logic [7:0] byte_t;

endpackage : sfp_mgmt_pkg

//--- src/sfp_mgmt_serial.sv
// Summary of operation
// - laser_fault_flag high while any laser fault exists, low otherwise.
// - Transmitter off while transmit_off_input high or open; only low enables it.
// - presence_indicator held to ground at all times.
// - signal_absent_flag high when no received signal, low in normal reception.
// - Answer at address 1010000X with a 256-byte identification memory.
// - Answer at 1010001X with diagnostics, identification page left unchanged.
// - Data captured on clock rise, stored only in unprotected segments.
// - Outgoing data shifted onto data line on clock fall.
// - Memories are 8-bit words, single or sequential access.
// - diagnostics_controller keeps temperature, bias, tx power, rx power, supply readable.
// - Alarm and warning flags set when a value leaves its range.
// - Values internally calibrated unless configured for external calibration.
// - Identification memory holds capability and maker data readable by host.
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sfp_mgmt_cfg.svh"

module sfp_mgmt_serial
    import sfp_mgmt_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic serial_clock_pin,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    output logic presence_out,
    output logic presence_oe,
    input wire logic laser_fault_in,
    input wire logic rx_signal_lost_in,
    input wire logic transmit_off_input,
    output logic tx_enable,
    output logic laser_fault_flag,
    output logic signal_absent_flag,
    input wire logic [7:0] monitor_temp,
    input wire logic [7:0] monitor_bias,
    input wire logic [7:0] monitor_txpwr,
    input wire logic [7:0] monitor_rxpwr,
    input wire logic [7:0] monitor_vcc,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq
);

    // ============================================================
    // Pin synchronisers
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_p_q;
    wire [4:0] pin_raw = {serial_clock_pin, serial_data_in, laser_fault_in,
                          rx_signal_lost_in, transmit_off_input};

    // Two flops per pin, then a history flop for edge finding
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_s1_q <= `PIN_SYNC_RST;
            pin_s2_q <= `PIN_SYNC_RST;
            pin_p_q <= `PIN_SYNC_RST;
        end else begin
            pin_s1_q <= pin_raw;
            pin_s2_q <= pin_s1_q;
            pin_p_q <= pin_s2_q;
        end
    end

    wire scl_s = pin_s2_q[4];
    wire sda_s = pin_s2_q[3];
    wire fault_s = pin_s2_q[2];
    wire los_s = pin_s2_q[1];
    wire txoff_s = pin_s2_q[0];
    wire scl_rise = scl_s && !pin_p_q[4];
    wire scl_fall = !scl_s && pin_p_q[4];
    // Frame marks: data edge while the clock stays high
    wire start_det = scl_s && pin_p_q[4] && pin_p_q[3] && !sda_s;
    wire stop_det = scl_s && pin_p_q[4] && !pin_p_q[3] && sda_s;

    // ============================================================
    // Status pins
    logic tx_enable_q;
    logic fault_flag_q;
    logic los_flag_q;
    logic presence_oe_q;
    logic sda_out_q;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            tx_enable_q <= 1'b0;
            fault_flag_q <= 1'b0;
            los_flag_q <= 1'b0;
            presence_oe_q <= 1'b1;
            sda_out_q <= 1'b0;
        end else begin
            tx_enable_q <= !txoff_s;
            fault_flag_q <= fault_s;
            los_flag_q <= los_s;
            presence_oe_q <= 1'b1;
            sda_out_q <= 1'b0;
        end
    end

    // ============================================================
    // Local registers
    logic [7:0] ctrl_q;
    logic [3:0] status_q;
    logic [3:0] mask_q;
    logic [7:0] cal_offset_q;
    logic [7:0] id_index_q;
    logic [7:0] reg_rdata_q;
    logic irq_q;
    byte_t id_mem [256];
    byte_t diag_mem [256];

    wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
    wire wr_mask = reg_wr && (reg_addr == `REG_MASK);
    wire wr_cal = reg_wr && (reg_addr == `REG_CAL_OFFSET);
    wire wr_idx = reg_wr && (reg_addr == `REG_ID_INDEX);
    wire wr_iddat = reg_wr && (reg_addr == `REG_ID_DATA);
    wire rd_status = reg_rd && (reg_addr == `REG_STATUS);
    wire ext_cal = ctrl_q[`CTRL_EXT_CAL_BIT];

    // ============================================================
    // Diagnostics controller: calibrated values and range flags
    byte_t raw [5];
    byte_t live [5];
    logic [4:0] alm_hi;
    logic [4:0] alm_lo;
    logic [4:0] wrn_hi;
    logic [4:0] wrn_lo;
    assign raw[0] = monitor_temp;
    assign raw[1] = monitor_bias;
    assign raw[2] = monitor_txpwr;
    assign raw[3] = monitor_rxpwr;
    assign raw[4] = monitor_vcc;

    // Per channel: offset calibration, thresholds from the page bytes 4i..4i+3
    for (genvar i = 0; i < 5; i++) begin : g_chan
        assign live[i] = ext_cal ? raw[i] : 8'(raw[i] + cal_offset_q);
        assign alm_hi[i] = live[i] > diag_mem[4 * i];
        assign alm_lo[i] = live[i] < diag_mem[4 * i + 1];
        assign wrn_hi[i] = live[i] > diag_mem[4 * i + 2];
        assign wrn_lo[i] = live[i] < diag_mem[4 * i + 3];
    end

    wire alarm_any = |{alm_hi, alm_lo, wrn_hi, wrn_lo};

    // ============================================================
    // Serial engine
    serial_state_t state_q;
    logic [3:0] cnt_q;
    byte_t shreg_q;
    byte_t ptr_q;
    logic sel_diag_q;
    logic rw_q;
    logic first_q;
    logic nack_q;
    logic sda_oe_q;
    byte_t diag_rd;

    // Page read: live words overlay the stored page
    wire [7:0] live_idx = ptr_q - `DIAG_LIVE_BASE;
    wire in_live = (ptr_q >= `DIAG_LIVE_BASE) && (live_idx < 8'h05);
    wire [7:0] stat_byte = {!tx_enable_q, 4'h0, fault_flag_q, los_flag_q, 1'b0};
    always_comb begin
        diag_rd = diag_mem[ptr_q];
        if (in_live) begin
            diag_rd = live[live_idx[2:0]];
        end else if (ptr_q == `DIAG_LIVE_STAT) begin
            diag_rd = stat_byte;
        end else if (ptr_q == `DIAG_ALM_HI) begin
            diag_rd = {3'h0, alm_hi};
        end else if (ptr_q == `DIAG_ALM_LO) begin
            diag_rd = {3'h0, alm_lo};
        end else if (ptr_q == `DIAG_WRN_HI) begin
            diag_rd = {3'h0, wrn_hi};
        end else if (ptr_q == `DIAG_WRN_LO) begin
            diag_rd = {3'h0, wrn_lo};
        end
    end

    wire [6:0] dev_addr = shreg_q[7:1];
    wire dev_hit = (dev_addr == `DEV_ID_ADDR) || (dev_addr == `DEV_DIAG_ADDR);
    wire byte_done = scl_fall && (cnt_q == `BYTE_BITS);
    // Identification page is never writable from the serial side
    wire wr_ok = sel_diag_q && ((ptr_q < `DIAG_THRESH_END) || (ptr_q >= `DIAG_USER_BASE));
    wire mem_wr = (state_q == S_RX) && byte_done && !first_q && wr_ok;
    wire [7:0] rd_byte = sel_diag_q ? diag_rd : id_mem[ptr_q];
    wire load_fire = scl_fall && (((state_q == S_DACK) && rw_q) || ((state_q == S_HACK) && !nack_q));

    // Byte-wide engine, stepping on clock edges of the host
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= S_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            ptr_q <= 8'h00;
            sel_diag_q <= 1'b0;
            rw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else if (stop_det) begin
            state_q <= S_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_det) begin
            state_q <= S_DEV;
            cnt_q <= 4'h0;
            sda_oe_q <= 1'b0;
        end else if (load_fire) begin
            shreg_q <= rd_byte;
            sda_oe_q <= !rd_byte[7];
            ptr_q <= ptr_q + 8'h01;
            cnt_q <= 4'h1;
            state_q <= S_TX;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                S_DEV: begin
                    if (scl_rise) begin
                        shreg_q <= {shreg_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        sel_diag_q <= shreg_q[1];
                        rw_q <= shreg_q[0];
                        sda_oe_q <= dev_hit;
                        state_q <= dev_hit ? S_DACK : S_IDLE;
                    end
                end
                S_DACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        first_q <= 1'b1;
                        state_q <= S_RX;
                    end
                end
                S_RX: begin
                    if (scl_rise) begin
                        shreg_q <= {shreg_q[6:0], sda_s};
                        cnt_q <= cnt_q + 4'h1;
                    end else if (byte_done) begin
                        ptr_q <= first_q ? shreg_q : ptr_q + 8'h01;
                        first_q <= 1'b0;
                        sda_oe_q <= 1'b1;
                        state_q <= S_WACK;
                    end
                end
                S_WACK: begin
                    if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        state_q <= S_RX;
                    end
                end
                S_TX: begin
                    if (scl_fall && (cnt_q == `BYTE_BITS)) begin
                        sda_oe_q <= 1'b0;
                        state_q <= S_HACK;
                    end else if (scl_fall) begin
                        sda_oe_q <= !shreg_q[6];
                        shreg_q <= {shreg_q[6:0], 1'b0};
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                S_HACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_s;
                    end else if (scl_fall) begin
                        state_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Memories: diagnostic page from the serial side, identity from software
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            for (int k = 0; k < 256; k++) begin
                diag_mem[k] <= 8'h00;
            end
        end else if (mem_wr) begin
            diag_mem[ptr_q] <= shreg_q;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr_iddat) begin
            id_mem[id_index_q] <= reg_wdata;
        end
    end

    // ============================================================
    // Register file, sticky events and interrupt
    logic fault_p_q;
    logic los_p_q;
    logic alarm_p_q;
    wire [3:0] events = {alarm_any && !alarm_p_q, los_flag_q && !los_p_q,
                         fault_flag_q && !fault_p_q, mem_wr};
    wire [7:0] rd_mux =
        (reg_addr == `REG_CTRL) ? ctrl_q :
        (reg_addr == `REG_STATUS) ? {4'h0, status_q} :
        (reg_addr == `REG_MASK) ? {4'h0, mask_q} :
        (reg_addr == `REG_CAL_OFFSET) ? cal_offset_q :
        (reg_addr == `REG_ID_INDEX) ? id_index_q :
        (reg_addr == `REG_ID_DATA) ? id_mem[id_index_q] :
        (reg_addr == `REG_LINE) ? stat_byte : 8'h00;

    // Set beats clear when an event lands on the status read
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_q <= `CTRL_RST;
            status_q <= 4'h0;
            mask_q <= `MASK_RST;
            cal_offset_q <= `CAL_OFFSET_RST;
            id_index_q <= 8'h00;
            reg_rdata_q <= 8'h00;
            irq_q <= 1'b0;
            fault_p_q <= 1'b0;
            los_p_q <= 1'b0;
            alarm_p_q <= 1'b0;
        end else begin
            ctrl_q <= wr_ctrl ? reg_wdata : ctrl_q;
            mask_q <= wr_mask ? reg_wdata[3:0] : mask_q;
            cal_offset_q <= wr_cal ? reg_wdata : cal_offset_q;
            id_index_q <= wr_idx ? reg_wdata : (wr_iddat ? id_index_q + 8'h01 : id_index_q);
            status_q <= (rd_status ? 4'h0 : status_q) | events;
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
            irq_q <= |(status_q & mask_q);
            fault_p_q <= fault_flag_q;
            los_p_q <= los_flag_q;
            alarm_p_q <= alarm_any;
        end
    end

    assign serial_data_out = sda_out_q;
    assign serial_data_oe = sda_oe_q;
    assign presence_out = sda_out_q;
    assign presence_oe = presence_oe_q;
    assign tx_enable = tx_enable_q;
    assign laser_fault_flag = fault_flag_q;
    assign signal_absent_flag = los_flag_q;
    assign reg_rdata = reg_rdata_q;
    assign irq = irq_q;

    // ============================================================
    // Assertions
    sequence s_addr_byte;
        (state_q == S_DEV) && byte_done && dev_hit;
    endsequence

    sequence s_ack_held;
        serial_data_oe [*1] ##1 (state_q == S_DACK);
    endsequence

    a_presence_ground: assert property (@(posedge mclk) disable iff (!rst_b)
        presence_oe && !presence_out)
        else $error("presence pin not driven low");
    a_fault_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(laser_fault_in) ##1 laser_fault_in [*2] |=> laser_fault_flag)
        else $error("fault flag missed fault input");
    a_los_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        $fell(rx_signal_lost_in) ##1 !rx_signal_lost_in [*2] |=> !signal_absent_flag)
        else $error("loss flag did not clear");
    a_tx_off_input: assert property (@(posedge mclk) disable iff (!rst_b)
        transmit_off_input [*4] |-> !tx_enable)
        else $error("transmitter on while disable input high");
    a_addr_ack: assert property (@(posedge mclk) disable iff (!rst_b)
        s_addr_byte |=> s_ack_held)
        else $error("no acknowledge for own address");
    a_id_protect: assert property (@(posedge mclk) disable iff (!rst_b)
        mem_wr |-> sel_diag_q && (ptr_q < 8'h28 || ptr_q >= 8'h80))
        else $error("write into protected segment");
    a_ptr_advance: assert property (@(posedge mclk) disable iff (!rst_b)
        load_fire |=> ptr_q == 8'($past(ptr_q) + 8'h01))
        else $error("pointer did not advance after byte");
    a_drive_on_fall: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(serial_data_oe) |-> $past(scl_fall))
        else $error("data line driven away from clock fall");
    a_cal_default: assert property (@(posedge mclk)
        !rst_b |=> !ext_cal && live[0] == 8'(monitor_temp + cal_offset_q))
        else $error("calibration not internal after reset");
    a_alarm_set: assert property (@(posedge mclk) disable iff (!rst_b)
        (live[1] > diag_mem[4]) |-> ##2 (status_q[`STS_ALARM_BIT] || $past(alarm_p_q, 2)))
        else $error("alarm event not recorded");

endmodule : sfp_mgmt_serial

//--- bench/sfp_host_model.sv
`timescale 1ns/1ps

// ============================================================
// Host controller on the two-wire management link
module sfp_host_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // Link idles released, clock parked high between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start, leaves the clock low
    // Long release waits out the module's late ack release and keeps off mclk edges
    task automatic start_cond();
        sda_low = 1'b0;
        #105 scl = 1'b1;
        #50 sda_low = 1'b1;
        #50 scl = 1'b0;
    endtask : start_cond

    // Stop, data rises while the clock is high
    task automatic stop_cond();
        #50 sda_low = 1'b1;
        #50 scl = 1'b1;
        #50 sda_low = 1'b0;
        #50;
    endtask : stop_cond

    // One 200 ns clock, data set mid low phase, sampled late in high phase
    task automatic bit_cycle(input logic drv_low, output logic seen);
        #50 sda_low = drv_low;
        #50 scl = 1'b1;
        #90 seen = sda;
        #10 scl = 1'b0;
    endtask : bit_cycle

    // Byte out, most significant bit first, then the module's answer
    task automatic write_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(!b[i], s);
        end
        bit_cycle(1'b0, s);
        ack = !s;
    endtask : write_byte

    // Byte in, then host ack, or nack on the last byte
    task automatic read_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b0, s);
            b[i] = s;
        end
        bit_cycle(!last, s);
    endtask : read_byte
endmodule : sfp_host_model

//--- bench/sfp_mgmt_serial_tb_top.sv
`timescale 1ns/1ps
`include "sfp_mgmt_cfg.svh"

// ============================================================
// Bench for the module management block
module sfp_mgmt_serial_tb_top
    import sfp_mgmt_pkg::*;
();
    logic mclk, rst_b, reg_wr, reg_rd;
    logic laser_fault_in, rx_signal_lost_in, transmit_off_input;
    logic serial_data_out, serial_data_oe, presence_out, presence_oe;
    logic tx_enable, laser_fault_flag, signal_absent_flag, irq;
    byte_t monitor_temp, monitor_bias, reg_addr, reg_wdata, reg_rdata;
    byte_t monitor_txpwr, monitor_rxpwr, monitor_vcc;
    wire serial_clock_pin;
    wire sda_low;
    wire serial_data_in;
    int error_cnt = 0;
    int num_checks = 0;
    byte_t rd_buf[5];
    byte_t wr_buf[4];

    // Data line with pull-up: low while the host pulls it or the module drives its level
    assign serial_data_in = !sda_low && !(serial_data_oe && !serial_data_out);

    sfp_mgmt_serial i_dut (
        .mclk, .rst_b, .serial_clock_pin, .serial_data_in,
        .serial_data_out, .serial_data_oe, .presence_out, .presence_oe,
        .laser_fault_in, .rx_signal_lost_in, .transmit_off_input,
        .tx_enable, .laser_fault_flag, .signal_absent_flag,
        .monitor_temp, .monitor_bias, .monitor_txpwr,
        .monitor_rxpwr, .monitor_vcc,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq
    );

    sfp_host_model i_host (
        .scl(serial_clock_pin),
        .sda_low(sda_low),
        .sda(serial_data_in)
    );

    // ============================================================
    // Clock and guard timer
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        #1000000;
        error_cnt++;
        finish_test();
    end

    // ============================================================
    // Shared tasks
    task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    // Wait whole cycles, then let the edge's updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc

    task automatic reg_write(input byte_t a, input byte_t d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input byte_t a, output byte_t d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic set_pins(input logic f, input logic l, input logic t);
        @(posedge mclk);
        laser_fault_in <= f;
        rx_signal_lost_in <= l;
        transmit_off_input <= t;
    endtask : set_pins

    // Start, device address for writing, word address
    task automatic ser_addr(input logic [6:0] dev, input byte_t wa);
        logic a;
        i_host.start_cond();
        i_host.write_byte({dev, 1'b0}, a);
        check("ack_dev", {7'h00, a}, 8'h01);
        i_host.write_byte(wa, a);
        check("ack_word", {7'h00, a}, 8'h01);
    endtask : ser_addr

    task automatic ser_write(input logic [6:0] dev, input byte_t wa, input int n);
        logic a;
        ser_addr(dev, wa);
        for (int i = 0; i < n; i++) begin
            i_host.write_byte(wr_buf[i], a);
            check("ack_data", {7'h00, a}, 8'h01);
        end
        i_host.stop_cond();
    endtask : ser_write

    task automatic ser_read(input logic [6:0] dev, input byte_t wa, input int n);
        logic a;
        ser_addr(dev, wa);
        i_host.start_cond();
        i_host.write_byte({dev, 1'b1}, a);
        check("ack_rd", {7'h00, a}, 8'h01);
        for (int i = 0; i < n; i++) begin
            i_host.read_byte(i == n - 1, rd_buf[i]);
        end
        i_host.stop_cond();
    endtask : ser_read

    // ============================================================
    // Scenarios
    task automatic t_pins();
        byte_t d;
        check("pres_oe", {7'h00, presence_oe}, 8'h01);
        check("pres_out", {7'h00, presence_out}, 8'h00);
        check("sda_out", {7'h00, serial_data_out}, 8'h00);
        check("tx_open", {7'h00, tx_enable}, 8'h00);
        set_pins(1'b1, 1'b1, 1'b1);
        cyc(6);
        check("fault_on", {7'h00, laser_fault_flag}, 8'h01);
        check("los_on", {7'h00, signal_absent_flag}, 8'h01);
        reg_read(`REG_LINE, d);
        check("line", d, 8'h86);
        set_pins(1'b0, 1'b0, 1'b0);
        cyc(6);
        check("fault_off", {7'h00, laser_fault_flag}, 8'h00);
        check("los_off", {7'h00, signal_absent_flag}, 8'h00);
        check("tx_on", {7'h00, tx_enable}, 8'h01);
        reg_read(`REG_STATUS, d);
        check("sts_events", d, 8'h06);
        reg_read(`REG_STATUS, d);
        check("sts_clear", d, 8'h00);
    endtask : t_pins

    task automatic t_irq();
        byte_t d;
        reg_write(`REG_MASK, 8'h00);
        set_pins(1'b1, 1'b0, 1'b0);
        cyc(6);
        check("irq_masked", {7'h00, irq}, 8'h00);
        reg_write(`REG_MASK, 8'h02);
        cyc(2);
        check("irq_up", {7'h00, irq}, 8'h01);
        reg_read(`REG_STATUS, d);
        check("sts_fault", d, 8'h02);
        cyc(2);
        check("irq_down", {7'h00, irq}, 8'h00);
        set_pins(1'b0, 1'b0, 1'b0);
    endtask : t_irq

    task automatic t_id_page();
        byte_t d;
        reg_write(`REG_ID_INDEX, 8'h10);
        for (int i = 0; i < 4; i++) begin
            reg_write(`REG_ID_DATA, 8'hA0 + i[7:0]);
        end
        reg_read(`REG_ID_INDEX, d);
        check("id_index", d, 8'h14);
        ser_read(`DEV_ID_ADDR, 8'h10, 4);
        for (int i = 0; i < 4; i++) begin
            check("id_byte", rd_buf[i], 8'hA0 + i[7:0]);
        end
        wr_buf[0] = 8'h5A;
        ser_write(`DEV_ID_ADDR, 8'h11, 1);
        ser_read(`DEV_ID_ADDR, 8'h11, 1);
        check("id_kept", rd_buf[0], 8'hA1);
    endtask : t_id_page

    task automatic t_diag();
        byte_t d;
        reg_write(`REG_CAL_OFFSET, 8'h05);
        @(posedge mclk);
        monitor_temp <= 8'h40;
        monitor_bias <= 8'h22;
        monitor_txpwr <= 8'h11;
        monitor_rxpwr <= 8'h12;
        monitor_vcc <= 8'h13;
        cyc(8);
        ser_read(`DEV_DIAG_ADDR, `DIAG_LIVE_BASE, 1);
        check("temp_cal", rd_buf[0], 8'h45);
        reg_write(`REG_CTRL, 8'h01);
        wr_buf = '{8'h50, 8'h00, 8'h30, 8'h00};
        ser_write(`DEV_DIAG_ADDR, 8'h00, 3);
        wr_buf[0] = 8'hFF;
        ser_write(`DEV_DIAG_ADDR, `DIAG_LIVE_BASE, 1);
        cyc(8);
        ser_read(`DEV_DIAG_ADDR, `DIAG_LIVE_BASE, 5);
        check("temp_raw", rd_buf[0], 8'h40);
        check("bias_raw", rd_buf[1], 8'h22);
        check("txpwr_raw", rd_buf[2], 8'h11);
        check("rxpwr_raw", rd_buf[3], 8'h12);
        check("vcc_raw", rd_buf[4], 8'h13);
        ser_read(`DEV_DIAG_ADDR, 8'h00, 3);
        check("thresh_0", rd_buf[0], 8'h50);
        check("thresh_1", rd_buf[1], 8'h00);
        check("thresh_2", rd_buf[2], 8'h30);
        ser_read(`DEV_DIAG_ADDR, `DIAG_ALM_HI, 2);
        check("alarm_hi", rd_buf[0], 8'h1E);
        check("alarm_lo", rd_buf[1], 8'h00);
        ser_read(`DEV_DIAG_ADDR, `DIAG_WRN_HI, 1);
        check("warn_hi", rd_buf[0], 8'h1F);
        reg_read(`REG_STATUS, d);
        check("sts_write", d & 8'h01, 8'h01);
    endtask : t_diag

    task automatic t_refused();
        byte_t d;
        logic a;
        i_host.start_cond();
        i_host.write_byte({7'h52, 1'b0}, a);
        check("nack", {7'h00, a}, 8'h00);
        i_host.stop_cond();
        reg_write(8'h20, 8'h77);
        reg_read(8'h20, d);
        check("unmapped", d, 8'h00);
        check("pres_end", {7'h00, presence_oe}, 8'h01);
    endtask : t_refused

    // ============================================================
    // Main sequence
    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        laser_fault_in = 1'b0;
        rx_signal_lost_in = 1'b0;
        transmit_off_input = 1'b1;
        monitor_temp = 8'h00;
        monitor_bias = 8'h00;
        monitor_txpwr = 8'h00;
        monitor_rxpwr = 8'h00;
        monitor_vcc = 8'h00;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        cyc(3);
        t_pins();
        t_irq();
        t_id_page();
        t_diag();
        t_refused();
        finish_test();
    end
endmodule : sfp_mgmt_serial_tb_top
